// ==== shared/status_led_params.svh ====
// constants for the status indicator block: offsets, reset values, timing
`ifndef STATUS_LED_PARAMS_SVH
`define STATUS_LED_PARAMS_SVH
// clock and blink timing
`define CLK_HZ          20000000
`define CLK_KHZ         (`CLK_HZ / 1000)
`define SLOT_MS         200
`define SLOT_CYC        (`CLK_KHZ * `SLOT_MS)
`define FRAME_SLOTS     4'd10
// pulses per frame for each blinking indication
`define PULSES_BUS_DIAG 3'd2
`define PULSES_FORCE    3'd3
`define PULSES_BUS_ERR  3'd4
`define PULSES_SW_WDT   3'd1
// register map, byte addresses on haddr[11:0]
`define ADDR_STATUS     12'h000
`define ADDR_WDT        12'h004
`define ADDR_AREA       12'h400
`define AREA_WORDS      140
`define AREA_SUM_WORD   8'h00
`define AREA_LAST_BYTE  558
`define STATUS_W        12
// reset values
`define WDT_TIME_RST    32'h000f_4240
`endif

// ==== shared/status_led_pkg.sv ====
// types shared by the status indicator block
package status_led_pkg;
    typedef enum logic [2:0] {
        DIAG_OFF      = 3'b000,
        DIAG_RUN      = 3'b001,
        DIAG_STOP     = 3'b010,
        DIAG_BUS_DIAG = 3'b011,
        DIAG_FORCE    = 3'b100,
        DIAG_BUS_ERR  = 3'b101
    } diag_pat_t;
    typedef enum logic [1:0] {
        WDOG_NONE = 2'b00,
        WDOG_SW   = 2'b01,
        WDOG_HW   = 2'b10
    } wdog_pat_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RD1  = 2'b01,
        BUS_RD2  = 2'b10
    } bus_st_t;
endpackage

// ==== hdl/diag_area_mem.sv ====
// diagnostic data area: one word per four bytes, registered read
`timescale 1ns/1ps
`default_nettype none
module diag_area_mem (
    input  wire logic        hclk,
    input  wire logic [7:0]  addr,
    input  wire logic        we,
    input  wire logic [3:0]  be,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata_r
);
    // one byte-wide array per lane so partial stores touch only their bytes;
    // each lane owns its storage, so no array has two writing processes
    for (genvar b = 0; b < 4; b++) begin : g_lane
        logic [7:0] mem [0:139];

        // read data always from a register, one edge after the address
        always_ff @(posedge hclk) begin
            if (we && be[b]) begin
                mem[addr] <= wdata[8*b +: 8];
            end
            rdata_r[8*b +: 8] <= mem[addr];
        end
    end
endmodule // diag_area_mem
`default_nettype wire

// ==== hdl/status_led_indicator.sv ====
// status indicator: diagnostic, watchdog and connector leds with an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "status_led_params.svh"
module status_led_indicator
    import status_led_pkg::*;
#(
    parameter int unsigned SLOT_CYCLES = `SLOT_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    input  wire logic        all_run,
    input  wire logic        all_stop,
    input  wire logic        bus_diag,
    input  wire logic        forcing,
    input  wire logic        bus_error,
    input  wire logic        app_busy,
    input  wire logic        app_reset,
    input  wire logic        hw_wdt_event,
    input  wire logic        link_up,
    input  wire logic        link_100,
    input  wire logic        link_activity,
    output logic             diag_indicator_led_green,
    output logic             diag_indicator_led_red,
    output logic             watchdog_indicator_led,
    output logic             watchdog_reset_flag,
    output logic             sw_watchdog_flag,
    output logic             conn_led_yellow,
    output logic             conn_led_green
);
    ////////////////////////////////////////////////////////////////////////////
    // bus slave state
    bus_st_t     st_r, st_nxt;
    logic        wr_pend_r, wr_pend_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic [3:0]  be_r, be_nxt;
    logic        hreadyout_r, hreadyout_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [31:0] wdt_time_r, wdt_time_nxt;
    logic [31:0] summ_r, summ_nxt;
    logic [31:0] mem_rdata;
    logic [7:0]  mem_idx;
    logic        in_area;
    logic        accept;
    logic [`STATUS_W-1:0] status;

    // watchdog and pattern state
    logic [31:0] busy_cnt_r, busy_cnt_nxt;
    logic        sw_wdt_r, sw_wdt_nxt;
    logic        hw_wdt_r, hw_wdt_nxt;
    diag_pat_t   diag_pat_r, diag_pat_nxt;
    wdog_pat_t   wdog_pat_r, wdog_pat_nxt;

    // blink timing and led state
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic [3:0]  slot_r, slot_nxt;
    logic        slot_end;
    logic        act_pend_r, act_pend_nxt;
    logic        act_off_r, act_off_nxt;
    logic        diag_green_r, diag_green_nxt;
    logic        diag_red_r, diag_red_nxt;
    logic        wdog_led_r, wdog_led_nxt;
    logic        yellow_r, yellow_nxt;
    logic        cgreen_r, cgreen_nxt;
    logic [2:0]  diag_pulses;
    logic        diag_blink, wdog_blink;

    ////////////////////////////////////////////////////////////////////////////
    // address decode; the area covers the summary and detail bytes rounded up to 140 whole words
    assign accept  = hsel && htrans[1] && hready;
    assign in_area = (addr_r >= `ADDR_AREA)
                  && (addr_r < 12'(`ADDR_AREA + 4 * `AREA_WORDS));
    assign mem_idx = 8'((addr_r - `ADDR_AREA) >> 2);
    assign status  = {cgreen_r, yellow_r, wdog_led_r, diag_red_r, diag_green_r,
                      hw_wdt_r, sw_wdt_r, wdog_pat_r, diag_pat_r};

    diag_area_mem u_area (
        .hclk    (hclk),
        .addr    (mem_idx),
        .we      (wr_pend_r && in_area),
        .be      (be_r),
        .wdata   (hwdata),
        .rdata_r (mem_rdata)
    );

    // reads take two wait cycles so the memory word is in a register first
    always_comb begin
        st_nxt        = st_r;
        wr_pend_nxt   = 1'b0;
        addr_nxt      = addr_r;
        be_nxt        = be_r;
        hreadyout_nxt = hreadyout_r;
        hrdata_nxt    = hrdata_r;
        unique case (st_r)
            BUS_IDLE: ;
            BUS_RD1: st_nxt = BUS_RD2;
            BUS_RD2: begin
                st_nxt        = BUS_IDLE;
                hreadyout_nxt = 1'b1;
                if (addr_r == `ADDR_STATUS) begin
                    hrdata_nxt = {20'h0_0000, status};
                end else if (addr_r == `ADDR_WDT) begin
                    hrdata_nxt = wdt_time_r;
                end else if (in_area) begin
                    hrdata_nxt = mem_rdata;
                end else begin
                    hrdata_nxt = 32'h0000_0000; // unmapped reads as zero
                end
            end
        endcase
        if (accept) begin
            addr_nxt = haddr[11:0];
            if (hsize == 3'h2) begin
                be_nxt = 4'hf;
            end else if (hsize == 3'h1) begin
                be_nxt = haddr[1] ? 4'hc : 4'h3;
            end else begin
                be_nxt = 4'(4'h1 << haddr[1:0]);
            end
            if (hwrite) begin
                wr_pend_nxt = 1'b1;
            end else begin
                st_nxt        = BUS_RD1;
                hreadyout_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r        <= BUS_IDLE;
            wr_pend_r   <= 1'b0;
            addr_r      <= 12'h000;
            be_r        <= 4'h0;
            hreadyout_r <= 1'b1;
            hrdata_r    <= 32'h0000_0000;
        end else begin
            st_r        <= st_nxt;
            wr_pend_r   <= wr_pend_nxt;
            addr_r      <= addr_nxt;
            be_r        <= be_nxt;
            hreadyout_r <= hreadyout_nxt;
            hrdata_r    <= hrdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software-visible registers: watchdog time and a copy of the summary word
    always_comb begin
        wdt_time_nxt = wdt_time_r;
        summ_nxt     = summ_r;
        for (int b = 0; b < 4; b++) begin
            if (wr_pend_r && be_r[b] && addr_r == `ADDR_WDT) begin
                wdt_time_nxt[8*b +: 8] = hwdata[8*b +: 8];
            end
            if (wr_pend_r && be_r[b] && in_area && mem_idx == `AREA_SUM_WORD) begin
                summ_nxt[8*b +: 8] = hwdata[8*b +: 8];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_time_r <= `WDT_TIME_RST;
            summ_r     <= 32'h0000_0000;
        end else begin
            wdt_time_r <= wdt_time_nxt;
            summ_r     <= summ_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog flags; a new event wins over a clear in the same cycle
    always_comb begin
        busy_cnt_nxt = 32'h0000_0000;
        if (app_busy && busy_cnt_r != 32'hffff_ffff) begin
            busy_cnt_nxt = busy_cnt_r + 32'h0000_0001;
        end else if (app_busy) begin
            busy_cnt_nxt = busy_cnt_r;
        end
        sw_wdt_nxt = (app_busy && busy_cnt_r > wdt_time_r)
                  || (sw_wdt_r && !app_reset);
        hw_wdt_nxt = hw_wdt_r || hw_wdt_event;
    end

    // hardware flag leaves only through the power-on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_cnt_r <= 32'h0000_0000;
            sw_wdt_r   <= 1'b0;
            hw_wdt_r   <= 1'b0;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
            sw_wdt_r   <= sw_wdt_nxt;
            hw_wdt_r   <= hw_wdt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // indication selection, strongest first
    always_comb begin
        if (bus_error) begin
            diag_pat_nxt = DIAG_BUS_ERR;
        end else if (bus_diag || summ_r != 32'h0000_0000) begin
            diag_pat_nxt = DIAG_BUS_DIAG;
        end else if (forcing) begin
            diag_pat_nxt = DIAG_FORCE;
        end else if (all_run) begin
            diag_pat_nxt = DIAG_RUN;
        end else if (all_stop) begin
            diag_pat_nxt = DIAG_STOP;
        end else begin
            diag_pat_nxt = DIAG_OFF; // mixed run and stop: nothing to claim
        end
        if (hw_wdt_r) begin
            wdog_pat_nxt = WDOG_HW;
        end else if (sw_wdt_r) begin
            wdog_pat_nxt = WDOG_SW;
        end else begin
            wdog_pat_nxt = WDOG_NONE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            diag_pat_r <= DIAG_OFF;
            wdog_pat_r <= WDOG_NONE;
        end else begin
            diag_pat_r <= diag_pat_nxt;
            wdog_pat_r <= wdog_pat_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame of ten slots; pulse n lights in slot 2n-2, the tail is the pause
    assign slot_end = (tick_cnt_r >= SLOT_CYCLES - 1);

    always_comb begin
        tick_cnt_nxt = slot_end ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
        slot_nxt     = slot_r;
        if (slot_end) begin
            slot_nxt = (slot_r == `FRAME_SLOTS - 4'd1) ? 4'h0 : slot_r + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_r <= 32'h0000_0000;
            slot_r     <= 4'h0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            slot_r     <= slot_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // led drivers
    always_comb begin
        unique case (diag_pat_r)
            DIAG_BUS_DIAG: diag_pulses = `PULSES_BUS_DIAG;
            DIAG_FORCE:    diag_pulses = `PULSES_FORCE;
            DIAG_BUS_ERR:  diag_pulses = `PULSES_BUS_ERR;
            default:       diag_pulses = 3'd0;
        endcase
        diag_blink = (slot_r < {diag_pulses, 1'b0}) && !slot_r[0];
        wdog_blink = (slot_r < {`PULSES_SW_WDT, 1'b0}) && !slot_r[0];
        diag_green_nxt = (diag_pat_r == DIAG_RUN)
                      || ((diag_pat_r == DIAG_BUS_DIAG || diag_pat_r == DIAG_FORCE)
                          && diag_blink);
        diag_red_nxt   = (diag_pat_r == DIAG_STOP)
                      || (diag_pat_r == DIAG_BUS_ERR && diag_blink);
        wdog_led_nxt   = (wdog_pat_r == WDOG_HW)
                      || (wdog_pat_r == WDOG_SW && wdog_blink);
        // traffic is latched and shown as one dark slot, so bursts merge
        act_pend_nxt = link_activity || (act_pend_r && !slot_end);
        act_off_nxt  = act_off_r;
        if (slot_end) begin
            act_off_nxt = act_pend_r;
        end
        yellow_nxt = link_up && !act_off_r;
        cgreen_nxt = link_up && link_100;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            diag_green_r <= 1'b0;
            diag_red_r   <= 1'b0;
            wdog_led_r   <= 1'b0;
            act_pend_r <= 1'b0;
            act_off_r  <= 1'b0;
            yellow_r   <= 1'b0;
            cgreen_r   <= 1'b0;
        end else begin
            diag_green_r <= diag_green_nxt;
            diag_red_r   <= diag_red_nxt;
            wdog_led_r   <= wdog_led_nxt;
            act_pend_r <= act_pend_nxt;
            act_off_r  <= act_off_nxt;
            yellow_r   <= yellow_nxt;
            cgreen_r   <= cgreen_nxt;
        end
    end

    // response never signals an error, kept in a flop like every output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    assign hreadyout                = hreadyout_r;
    assign hrdata                   = hrdata_r;
    assign diag_indicator_led_green = diag_green_r;
    assign diag_indicator_led_red   = diag_red_r;
    assign watchdog_indicator_led   = wdog_led_r;
    assign watchdog_reset_flag      = hw_wdt_r;
    assign sw_watchdog_flag         = sw_wdt_r;
    assign conn_led_yellow          = yellow_r;
    assign conn_led_green           = cgreen_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_run_steady_green: assert property (
        $past(diag_pat_r) == DIAG_RUN |-> diag_green_r && !diag_red_r)
        else $error("run indication not steady green");
    a_stop_steady_red: assert property (
        $past(diag_pat_r) == DIAG_STOP |-> diag_red_r && !diag_green_r)
        else $error("stop indication not steady red");
    a_two_pulse_pause: assert property (
        $past(diag_pat_r) == DIAG_BUS_DIAG && $past(slot_r) >= 4'd4
        |-> !diag_green_r && !diag_red_r)
        else $error("bus diagnostic blinks past its second pulse");
    a_force_third_pulse: assert property (
        $past(diag_pat_r) == DIAG_FORCE && $past(slot_r) == 4'd4
        |-> diag_green_r && !diag_red_r)
        else $error("forcing pattern lacks its third pulse");
    a_bus_err_fourth: assert property (
        $past(diag_pat_r) == DIAG_BUS_ERR && $past(slot_r) == 4'd6
        |-> diag_red_r && !diag_green_r)
        else $error("bus error pattern lacks its fourth pulse");
    // pattern and pulse count are checked in the same cycle: the inputs may
    // drop right after the sampled edge, so a later cycle proves nothing
    a_bus_err_wins: assert property (
        bus_error && forcing |=> diag_pat_r == DIAG_BUS_ERR && diag_pulses == 3'd4)
        else $error("bus error did not take precedence");
    a_sw_wdt_set: assert property (
        app_busy && busy_cnt_r > wdt_time_r
        |=> sw_watchdog_flag ##1 wdog_pat_r != WDOG_NONE)
        else $error("overrun did not flag the software watchdog");
    a_sw_wdt_hold: assert property (
        sw_wdt_r && !app_reset |=> sw_wdt_r)
        else $error("software watchdog cleared without application reset");
    a_hw_wdt_steady: assert property (
        hw_wdt_event |=> watchdog_reset_flag ##2 watchdog_indicator_led [*3])
        else $error("hardware watchdog not held steady");
    a_no_link_dark: assert property (
        !link_up |=> !conn_led_yellow && !conn_led_green)
        else $error("connector leds lit without link");
    a_read_two_waits: assert property (
        accept && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
        else $error("read answer not after two wait cycles");

    c_bus_err_shown: cover property (diag_pat_r == DIAG_BUS_ERR && diag_red_r);
    c_sw_wdt_blink: cover property (wdog_pat_r == WDOG_SW && wdog_led_r);
    c_activity_dark: cover property (link_up && act_off_r && !yellow_r);
    c_area_read: cover property (st_r == BUS_RD2 && in_area);
endmodule // status_led_indicator
`default_nettype wire

// ==== sim/led_panel_model.sv ====
// led panel model: counts lit cycles and turn-on events of each lamp
`timescale 1ns/1ps
`default_nettype none
module led_panel_model (
    input  wire logic            hclk,
    input  wire logic            clr,
    input  wire logic [3:0]      led,
    output logic      [3:0][7:0] rises,
    output logic      [3:0][7:0] lit
);
    logic [3:0] prev_r;
    // a lamp keeps no state: only what the pin shows in each cycle counts
    always_ff @(posedge hclk) begin
        prev_r <= led;
        for (int i = 0; i < 4; i++) begin
            rises[i] <= clr ? 8'h00 : rises[i] + 8'(led[i] & ~prev_r[i]);
            lit[i]   <= clr ? 8'h00 : lit[i] + 8'(led[i]);
        end
    end
endmodule // led_panel_model
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the status indicator block
`timescale 1ns/1ps
`default_nettype none
`include "status_led_params.svh"
module tb;
    // short slots keep a frame at 40 cycles
    localparam int unsigned SLOT = 4;
    logic            hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]      htrans = 2'b00;
    logic [2:0]      hsize = 3'd2;
    logic [31:0]     haddr = '0, hwdata = '0, hrdata;
    logic            hreadyout, hresp, clr = 1'b0;
    logic            all_run = 1'b0, all_stop = 1'b0, bus_diag = 1'b0, forcing = 1'b0;
    logic            bus_error = 1'b0, app_busy = 1'b0, app_reset = 1'b0, hw_wdt_event = 1'b0;
    logic            link_up = 1'b0, link_100 = 1'b0, link_activity = 1'b0;
    logic            g, r, wled, wdf, swf, cy, cg;
    logic [3:0][7:0] rises, lit;
    int              mismatches = 0, comparisons = 0;

    always #25 hclk = ~hclk;

    status_led_indicator #(.SLOT_CYCLES(SLOT)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .all_run(all_run),
        .all_stop(all_stop), .bus_diag(bus_diag), .forcing(forcing),
        .bus_error(bus_error), .app_busy(app_busy), .app_reset(app_reset),
        .hw_wdt_event(hw_wdt_event), .link_up(link_up), .link_100(link_100),
        .link_activity(link_activity), .diag_indicator_led_green(g),
        .diag_indicator_led_red(r), .watchdog_indicator_led(wled),
        .watchdog_reset_flag(wdf), .sw_watchdog_flag(swf), .conn_led_yellow(cy),
        .conn_led_green(cg)
    );

    led_panel_model i_panel (
        .hclk(hclk), .clr(clr), .led({cy, wled, r, g}), .rises(rises), .lit(lit)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // waits as long as the slave needs; only the bench watchdog ends a hang
    task automatic wait_rdy();
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask

    // one single ahb-lite word transfer
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    // settle, then count one whole frame of 10 slots at the panel
    task automatic frame(input int settle);
        repeat (settle) @(posedge hclk);
        @(posedge hclk);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        repeat (10 * SLOT + 1) @(posedge hclk);
    endtask

    task automatic leds(input int i, input logic [7:0] er, input logic [7:0] el);
        chk(32'(rises[i]), 32'(er));
        chk(32'(lit[i]), 32'(el));
    endtask

    task automatic show(input logic [4:0] s, input logic [7:0] gr, input logic [7:0] gl,
                        input logic [7:0] rr, input logic [7:0] rl);
        @(posedge hclk);
        {bus_error, bus_diag, forcing, all_run, all_stop} <= s;
        frame(12 * SLOT);
        leds(0, gr, gl);
        leds(1, rr, rl);
    endtask

    task automatic strobe(input logic [2:0] m);
        @(posedge hclk);
        {app_reset, hw_wdt_event, link_activity} <= m;
        @(posedge hclk);
        {app_reset, hw_wdt_event, link_activity} <= 3'b000;
        repeat (3) @(posedge hclk);
    endtask

    task automatic busy(input int n);
        @(posedge hclk);
        app_busy <= 1'b1;
        repeat (n) @(posedge hclk);
        app_busy <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // the watchdog allows several times the expected run length
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(32'({hresp, g, r, wled, wdf, swf, cy, cg}), 32'h0);
        chk(32'(hreadyout), 32'h1);
        rd_chk(`ADDR_WDT, `WDT_TIME_RST);
        rd_chk(32'h0000_0ffc, 32'h0);
        $display("test reset done");
        show(5'b00000, 8'd0, 8'd0, 8'd0, 8'd0);
        show(5'b00001, 8'd0, 8'd0, 8'd0, 8'd40);
        show(5'b01010, 8'd2, 8'(2 * SLOT), 8'd0, 8'd0);
        show(5'b00110, 8'd3, 8'(3 * SLOT), 8'd0, 8'd0);
        show(5'b01100, 8'd2, 8'(2 * SLOT), 8'd0, 8'd0);
        show(5'b11110, 8'd0, 8'd0, 8'd4, 8'(4 * SLOT));
        show(5'b00010, 8'd0, 8'd40, 8'd0, 8'd0);
        $display("test priority done");
        // status is read only: a write must leave the run code and green lamp
        wr(`ADDR_STATUS, 32'hffff_ffff);
        rd_chk(`ADDR_STATUS, 32'h0000_0081);
        wr(32'h0000_062c, 32'h8899_aabb);
        rd_chk(32'h0000_062c, 32'h8899_aabb);
        rd_chk(32'h0000_0630, 32'h0);
        wr(32'h0000_0404, 32'h0000_00ff);
        wr(`ADDR_AREA, 32'h0000_0001);
        show(5'b00010, 8'd2, 8'(2 * SLOT), 8'd0, 8'd0);
        wr(`ADDR_AREA, 32'h0);
        show(5'b00010, 8'd0, 8'd40, 8'd0, 8'd0);
        rd_chk(32'h0000_0404, 32'h0000_00ff);
        $display("test area done");
        wr(`ADDR_WDT, 32'h5);
        busy(5);
        chk(32'(swf), 32'h0);
        busy(7);
        chk(32'(swf), 32'h1);
        frame(12 * SLOT);
        leds(2, 8'd1, 8'(SLOT));
        chk(32'(swf), 32'h1);
        strobe(3'b100);
        chk(32'(swf), 32'h0);
        frame(12 * SLOT);
        leds(2, 8'd0, 8'd0);
        $display("test software watchdog done");
        busy(7);
        strobe(3'b010);
        chk(32'(wdf), 32'h1);
        frame(12 * SLOT);
        leds(2, 8'd0, 8'd40);
        strobe(3'b100);
        frame(12 * SLOT);
        leds(2, 8'd0, 8'd40);
        chk(32'(wdf), 32'h1);
        $display("test hardware watchdog done");
        @(posedge hclk);
        link_up <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(32'({cy, cg}), 32'h2);
        link_100 <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(32'({cy, cg}), 32'h3);
        // activity darkens yellow for one slot on the block's own schedule
        fork
            frame(0);
            strobe(3'b001);
        join
        leds(3, 8'd1, 8'(10 * SLOT - SLOT));
        frame(12 * SLOT);
        leds(3, 8'd0, 8'd40);
        link_up <= 1'b0;
        repeat (3) @(posedge hclk);
        chk(32'({cy, cg}), 32'h0);
        $display("test connector done");
        wrap_up();
    end
endmodule // tb
`default_nettype wire
